// *** logic/scp_pkg.sv ***
/*
 System clock and power mode package: register offsets, field positions,
 reset values, clock rates and the mode and switch state encodings.
 Assumes a 20 MHz bus clock and byte addresses on an 8-bit APB address.
*/
package scp_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] CTL_OFS = 8'h00;
   localparam logic [7:0] OSC_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;

   localparam int CTL_SEL_LO = 5;
   localparam int CTL_FIDLE = 1;
   localparam int CTL_SIDLE = 0;
   localparam int OSC_STABLE = 1;
   localparam int OSC_EN = 0;
   localparam int STAT_PWRDN = 0;
   localparam int STAT_TIMEOUT = 1;
   localparam int STAT_MODE_LO = 2;
   localparam int STAT_SWITCH = 5;
   localparam int STAT_SLOW_OK = 6;

   localparam logic [2:0] SEL_RST = 3'h1;
   localparam logic SIDLE_RST = 1'b0;
   localparam logic FIDLE_RST = 1'b0;
   localparam logic OSC_EN_RST = 1'b1;
   localparam logic [2:0] SEL_SUB = 3'h7;

   localparam int CLK_HZ = 20_000_000;
   localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
   localparam int FAST_HZ = 16_000_000;
   localparam int SLOW_HZ = 32_000;
   localparam int TICK_SCALE = 1000;
   localparam int TICK_MOD = CLK_HZ / TICK_SCALE;
   localparam int FAST_INC = FAST_HZ / TICK_SCALE;
   localparam int SLOW_INC = SLOW_HZ / TICK_SCALE;
   localparam logic [2:0] SW_CUR_TICKS = 3'h4;

   typedef enum logic [2:0] {
      MD_RUN = 3'b000,
      MD_SLEEP = 3'b001,
      MD_IDLE_SUB = 3'b010,
      MD_IDLE_BOTH = 3'b011,
      MD_IDLE_FAST = 3'b100
   } scp_mode_e;

   typedef enum logic [1:0] {
      SW_STEADY = 2'b00,
      SW_DRAIN = 2'b01,
      SW_ALIGN = 2'b10
   } scp_sw_e;
endpackage

// *** logic/scp_tick.sv ***
/*
 Oscillator model: a phase accumulator that turns the bus clock into a
 one-cycle enable pulse at INC/MOD of its rate while run is high.
 Assumes run comes from logic on the same clock.
*/
module scp_tick #(
   parameter int INC = 16,
   parameter int MOD = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   output logic tick
);
   typedef struct packed {
      logic [15:0] acc;
      logic tick;
   } scp_tick_s;

   scp_tick_s q, d;
   logic [16:0] sum;

   if (INC < 1 || INC >= MOD || MOD > 32767) begin : g_bad
      $error("scp_tick: INC must lie in 1..MOD-1 and MOD below 32768");
   end

   always_comb begin
      sum = 17'(q.acc) + 17'(INC);
      d = q;
      d.tick = 1'b0;
      if (!run) begin
         d.acc = 16'h0000;
      end else if (sum >= 17'(MOD)) begin
         d.acc = 16'(sum - 17'(MOD));
         d.tick = 1'b1;
      end else begin
         d.acc = sum[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick = q.tick;
endmodule // scp_tick

// *** logic/scp_top.sv ***
/*
 System clock selection and low power modes with an APB register slave.
 Oscillators are modelled as enable pulses on pclk; every clock output is a
 one-cycle enable. Assumes halt_req, sys_irq, watchdog_overflow and
 watchdog_clr_instr come from logic on pclk; porta_pins come from pins.
*/

module scp_top import scp_pkg::*; #(
   parameter int FAST_START_CYC = 16,
   parameter int SLOW_START_CYC = 16,
   parameter int PORTA_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic halt_req,
   input wire logic sys_irq,
   input wire logic watchdog_overflow,
   input wire logic watchdog_clr_instr,
   input wire logic [PORTA_W-1:0] porta_pins,
   output logic system_clk_en,
   output logic cpu_clk_en,
   output logic fast_clk_en,
   output logic sub_clk_en,
   output logic slow_osc_clk_en,
   output logic fast_osc_run,
   output logic cpu_on,
   output logic watchdog_clear,
   output logic powerdown_flag,
   output logic timeout_flag
);
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [2:0] clk_select;
      logic fast_osc_idle_en;
      logic slow_osc_idle_en;
      logic fast_osc_enable;
      logic fast_osc_stable;
      logic [15:0] fast_cnt;
      logic slow_stable;
      logic [15:0] slow_cnt;
      logic fast_run;
      logic [5:0] div;
      logic [2:0] act_sel;
      scp_sw_e sw;
      logic [2:0] sw_cnt;
      scp_mode_e mode;
      logic powerdown_flag;
      logic timeout_flag;
      logic wd_clr;
      logic [PORTA_W-1:0] pa1;
      logic [PORTA_W-1:0] pa2;
      logic [PORTA_W-1:0] pa3;
      logic sys_en;
      logic cpu_en;
      logic fast_en;
      logic sub_en;
      logic osc_slow_en;
      logic cpu_run;
   } scp_state_s;

   scp_state_s q, d;
   logic fast_tick;
   logic slow_tick;
   logic setup;
   logic wr;
   logic wake;
   logic run_now;
   logic sub_on;
   logic fast_need;
   logic cur_tick;
   logic tar_tick;
   logic tar_ready;

   if (FAST_START_CYC < 1 || FAST_START_CYC > 65535 || SLOW_START_CYC < 1 || SLOW_START_CYC > 65535) begin : g_bad
      $error("scp_top: start counts must lie in 1..65535");
   end
   if (PORTA_W < 1 || PORTA_W > 32) begin : g_bad_pa
      $error("scp_top: PORTA_W must lie in 1..32");
   end

   // Fast divider taps: code n passes every 2**n-th fast tick
   function automatic logic [5:0] div_mask(input logic [2:0] sel);
      div_mask = 6'((7'h01 << sel) - 7'h01);
   endfunction

   function automatic logic src_tick(input logic [2:0] sel, input logic ft, input logic st,
                                     input logic [5:0] dv, input logic sub_ok);
      if (sel == SEL_SUB) begin
         src_tick = st & sub_ok;
      end else begin
         src_tick = ft & ((dv & div_mask(sel)) == div_mask(sel));
      end
   endfunction

   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      addr_ok = (a == CTL_OFS) || (a == OSC_OFS) || (a == STAT_OFS);
   endfunction

   scp_tick #(.INC(FAST_INC), .MOD(TICK_MOD)) u_fast (
      .pclk(pclk),
      .presetn(presetn),
      .run(q.fast_run & q.fast_osc_stable),
      .tick(fast_tick)
   );

   // Free running: the watchdog depends on it in every mode
   scp_tick #(.INC(SLOW_INC), .MOD(TICK_MOD)) u_slow (
      .pclk(pclk),
      .presetn(presetn),
      .run(1'b1),
      .tick(slow_tick)
   );

   always_comb begin
      d = q;
      setup = psel & ~penable;
      wr = psel & penable & q.pready & pwrite & ~q.pslverr & pstrb[0];
      run_now = (q.mode == MD_RUN);
      wake = (|(q.pa3 & ~q.pa2)) | sys_irq | watchdog_overflow;
      sub_on = run_now | q.slow_osc_idle_en;
      // In run mode fast osc forced on while it feeds the CPU or is the switch target
      if (run_now) begin
         fast_need = q.fast_osc_enable | (q.act_sel != SEL_SUB)
                     | ((q.sw != SW_STEADY) & (q.clk_select != SEL_SUB));
      end else begin
         fast_need = q.fast_osc_idle_en;
      end
      cur_tick = src_tick(q.act_sel, fast_tick, slow_tick, q.div, sub_on);
      tar_tick = src_tick(q.clk_select, fast_tick, slow_tick, q.div, sub_on);
      tar_ready = (q.clk_select == SEL_SUB) ? q.slow_stable : q.fast_osc_stable;

      // Bus slave, data registered at setup so the answer is a flop
      d.pready = setup;
      d.pslverr = setup & ~addr_ok(paddr);
      if (setup) begin
         case (paddr)
            CTL_OFS: d.prdata = {24'h000000, q.clk_select, 3'h0, q.fast_osc_idle_en, q.slow_osc_idle_en};
            OSC_OFS: d.prdata = {30'h00000000, q.fast_osc_stable, q.fast_osc_enable};
            STAT_OFS: d.prdata = {25'h0000000, q.slow_stable, q.sw != SW_STEADY, q.mode,
                                  q.timeout_flag, q.powerdown_flag};
            default: d.prdata = 32'h00000000;
         endcase
      end
      if (wr && paddr == CTL_OFS) begin
         d.clk_select = pwdata[CTL_SEL_LO+2:CTL_SEL_LO];
         d.fast_osc_idle_en = pwdata[CTL_FIDLE];
         d.slow_osc_idle_en = pwdata[CTL_SIDLE];
      end
      if (wr && paddr == OSC_OFS) begin
         d.fast_osc_enable = pwdata[OSC_EN];
      end

      // Fast oscillator start-up
      d.fast_run = fast_need;
      if (!fast_need) begin
         d.fast_osc_stable = 1'b0;
         d.fast_cnt = 16'h0000;
      end else if (!q.fast_osc_stable) begin
         if (q.fast_cnt == 16'(FAST_START_CYC - 1)) begin
            d.fast_osc_stable = 1'b1;
         end else begin
            d.fast_cnt = q.fast_cnt + 16'h0001;
         end
      end
      if (!q.slow_stable) begin
         if (q.slow_cnt == 16'(SLOW_START_CYC - 1)) begin
            d.slow_stable = 1'b1;
         end else begin
            d.slow_cnt = q.slow_cnt + 16'h0001;
         end
      end
      if (fast_tick) begin
         d.div = q.div + 6'h01;
      end

      // Source switch: finish current periods, go quiet, join on a target edge
      case (q.sw)
         SW_STEADY: begin
            if (q.clk_select != q.act_sel) begin
               d.sw = SW_DRAIN;
               d.sw_cnt = 3'h0;
            end
         end
         SW_DRAIN: begin
            if (cur_tick) begin
               if (q.sw_cnt == SW_CUR_TICKS - 3'h1) begin
                  d.sw = SW_ALIGN;
               end else begin
                  d.sw_cnt = q.sw_cnt + 3'h1;
               end
            end
         end
         SW_ALIGN: begin
            if (tar_tick && tar_ready) begin
               d.act_sel = q.clk_select;
               d.sw = SW_STEADY;
            end
         end
         default: d.sw = SW_STEADY;
      endcase
      if (q.sw == SW_ALIGN) begin
         d.sys_en = tar_tick & tar_ready;
      end else begin
         d.sys_en = cur_tick;
      end
      d.cpu_en = d.sys_en & run_now;
      d.fast_en = fast_tick;
      d.sub_en = slow_tick & sub_on;
      d.osc_slow_en = slow_tick;

      // Operating modes
      d.wd_clr = 1'b0;
      if (watchdog_clr_instr) begin
         d.powerdown_flag = 1'b0;
      end
      case (q.mode)
         MD_RUN: begin
            if (halt_req) begin
               case ({q.fast_osc_idle_en, q.slow_osc_idle_en})
                  2'b00: d.mode = MD_SLEEP;
                  2'b01: d.mode = MD_IDLE_SUB;
                  2'b11: d.mode = MD_IDLE_BOTH;
                  default: d.mode = MD_IDLE_FAST;
               endcase
               d.powerdown_flag = 1'b1;
               d.timeout_flag = 1'b0;
               d.wd_clr = 1'b1;
            end
         end
         MD_SLEEP, MD_IDLE_SUB, MD_IDLE_BOTH, MD_IDLE_FAST: begin
            if (wake) begin
               d.mode = MD_RUN;
            end
         end
         default: d.mode = MD_RUN;
      endcase
      // Overflow wins over the halt clear in the same cycle
      if (watchdog_overflow) begin
         d.timeout_flag = 1'b1;
      end
      // Copy of the next mode so cpu_on leaves a flop without extra latency
      d.cpu_run = (d.mode == MD_RUN);

      d.pa1 = porta_pins;
      d.pa2 = q.pa1;
      d.pa3 = q.pa2;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.clk_select <= SEL_RST;
         q.act_sel <= SEL_RST;
         q.fast_osc_idle_en <= FIDLE_RST;
         q.slow_osc_idle_en <= SIDLE_RST;
         q.fast_osc_enable <= OSC_EN_RST;
         q.sw <= SW_STEADY;
         q.mode <= MD_RUN;
         q.cpu_run <= 1'b1;
         q.pa1 <= '1;
         q.pa2 <= '1;
         q.pa3 <= '1;
      end else begin
         q <= d;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign system_clk_en = q.sys_en;
   assign cpu_clk_en = q.cpu_en;
   assign fast_clk_en = q.fast_en;
   assign sub_clk_en = q.sub_en;
   assign slow_osc_clk_en = q.osc_slow_en;
   assign fast_osc_run = q.fast_run;
   assign cpu_on = q.cpu_run;
   assign watchdog_clear = q.wd_clr;
   assign powerdown_flag = q.powerdown_flag;
   assign timeout_flag = q.timeout_flag;

   // Checks
   localparam int SW_LIMIT = 8000;
   logic [13:0] sw_age;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_age <= 14'h0000;
      end else if (q.sw == SW_STEADY) begin
         sw_age <= 14'h0000;
      end else begin
         sw_age <= sw_age + 14'h0001;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_halt(logic f, logic s);
      q.mode == MD_RUN && halt_req && q.fast_osc_idle_en == f && q.slow_osc_idle_en == s;
   endsequence
   sequence s_fresh_start;
      $rose(q.fast_run) ##1 !q.fast_osc_stable;
   endsequence

   a_halt_sleep: assert property (s_halt(1'b0, 1'b0) |=> q.mode == MD_SLEEP ##1 !sub_clk_en && !cpu_clk_en)
      else $error("halt with idle bits 00 did not sleep");
   a_halt_idle_sub: assert property (s_halt(1'b0, 1'b1) |=> q.mode == MD_IDLE_SUB ##1 !q.fast_run)
      else $error("halt with idle bits 01 wrong");
   a_halt_idle_both: assert property (s_halt(1'b1, 1'b1) |=> q.mode == MD_IDLE_BOTH ##1 fast_osc_run)
      else $error("halt with idle bits 11 wrong");
   a_halt_idle_fast: assert property (s_halt(1'b1, 1'b0) |=> q.mode == MD_IDLE_FAST ##1 !sub_clk_en)
      else $error("halt with idle bits 10 wrong");
   a_slow_always: assert property (!slow_osc_clk_en |-> ##[1:700] slow_osc_clk_en)
      else $error("slow oscillator clock stopped");
   a_stable_wait: assert property (s_fresh_start |-> !q.fast_osc_stable [*1] ##1 !fast_clk_en)
      else $error("stable flag not cleared on enable");
   a_switch_bound: assert property (sw_age < 14'(SW_LIMIT))
      else $error("clock switch took too long");
   a_sub_stable: assert property (q.sw == SW_ALIGN && q.clk_select == SEL_SUB && !q.slow_stable
                                  |=> q.act_sel != SEL_SUB)
      else $error("sub clock taken before slow oscillator stable");
   a_halt_flags: assert property (q.mode == MD_RUN && halt_req && !watchdog_overflow
                                  |=> powerdown_flag && !timeout_flag && watchdog_clear)
      else $error("halt flags wrong");
   a_wake_irq: assert property (q.mode != MD_RUN && sys_irq |=> cpu_on)
      else $error("interrupt did not wake");
   a_reserved_zero: assert property (pready && !pslverr && $past(paddr) == CTL_OFS |-> prdata[4:2] == 3'h0)
      else $error("reserved bits not zero");
   a_no_pulse_align: assert property (q.sw == SW_ALIGN && !(tar_tick && tar_ready) |=> !system_clk_en)
      else $error("system clock pulse during switch gap");
endmodule // scp_top

// *** verification/tb_system_clock_and_power_modes.sv ***
/*
 Testbench for scp_top: APB register access, clock select and divide,
 fast oscillator enable, halt into each low power mode and wake-up.
 Assumes scp_pkg is compiled first; the fast start-up wait is shortened, the slow one lengthened.
*/
module tb_system_clock_and_power_modes import scp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'hF;
   logic halt_req = 1'b0, sys_irq = 1'b0, watchdog_overflow = 1'b0, watchdog_clr_instr = 1'b0;
   logic [7:0] porta_pins = 8'hFF;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, system_clk_en, cpu_clk_en, fast_clk_en, sub_clk_en;
   logic slow_osc_clk_en, fast_osc_run, cpu_on, watchdog_clear, powerdown_flag, timeout_flag;
   logic [2:0] mode_tab [4] = '{MD_SLEEP, MD_IDLE_SUB, MD_IDLE_FAST, MD_IDLE_BOTH};
   int fails = 0, total_checks = 0, cyc = 0;
   int cnt [5] = '{default: 0};
   int base [5], dl [5];
   // Slow start outlasts one slow period, so the first sub switch must wait for it
   localparam int SLOW_WAIT = 1000;

   scp_top #(.FAST_START_CYC(2), .SLOW_START_CYC(SLOW_WAIT), .PORTA_W(8)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .halt_req(halt_req), .sys_irq(sys_irq), .watchdog_overflow(watchdog_overflow),
      .watchdog_clr_instr(watchdog_clr_instr), .porta_pins(porta_pins), .system_clk_en(system_clk_en),
      .cpu_clk_en(cpu_clk_en), .fast_clk_en(fast_clk_en), .sub_clk_en(sub_clk_en),
      .slow_osc_clk_en(slow_osc_clk_en), .fast_osc_run(fast_osc_run), .cpu_on(cpu_on),
      .watchdog_clear(watchdog_clear), .powerdown_flag(powerdown_flag), .timeout_flag(timeout_flag));

   always #25 pclk = ~pclk;

   task automatic tally_and_finish();
      if (fails == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Enable pulse counters; a hang is cut short well past the planned run
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      cnt[0] <= cnt[0] + int'(system_clk_en === 1'b1);
      cnt[1] <= cnt[1] + int'(cpu_clk_en === 1'b1);
      cnt[2] <= cnt[2] + int'(fast_clk_en === 1'b1);
      cnt[3] <= cnt[3] + int'(sub_clk_en === 1'b1);
      cnt[4] <= cnt[4] + int'(slow_osc_clk_en === 1'b1);
      if (cyc == 60000) begin
         fails = fails + 1;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi, input string msg);
      total_checks++;
      if (got < lo || got > hi) begin
         fails++;
         $display("wrong value at %0t: %s got %0d expected %0d..%0d", $time, msg, got, lo, hi);
      end
   endtask

   // Setup, then access held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
         chk(1'b0, 1'b1, "no pready");
   endtask

   // Clock period in pclk cycles for a selector code, rounded up
   function automatic int per(input int k);
      return (k == 7) ? 625 : ((5 << k) + 3) / 4;
   endfunction

   task automatic wait_switch(input int bound);
      int t0;
      t0 = cyc;
      do
         apb(1'b0, STAT_OFS, 32'h0);
      while (rd[STAT_SWITCH] !== 1'b0 && cyc - t0 < 4000);
      chk_rng(cyc - t0, 0, bound + 8, "switch time");
   endtask

   task automatic span(input int n);
      // Pulses already in the output pipeline drain before counting starts
      repeat (4) @(posedge pclk);
      base = cnt;
      repeat (n) @(posedge pclk);
      #1;
      for (int i = 0; i < 5; i++)
         dl[i] = cnt[i] - base[i];
   endtask

   initial begin
      int n, ex, prev;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (20) @(posedge pclk);
      #1 chk(cpu_on, 1'b1, "cpu on after reset");
      apb(1'b0, CTL_OFS, 32'h0);
      chk(rd, 32'h20, "control reset");
      apb(1'b0, OSC_OFS, 32'h0);
      chk(rd, 32'h3, "osc reset");
      apb(1'b0, 8'h0C, 32'h0);
      chk({rd[30:0], err}, 32'h1, "unmapped");
      // Sub clock picked while the slow oscillator still starts: first slow tick is skipped
      apb(1'b1, CTL_OFS, 32'hE0);
      wait_switch(SLOW_WAIT + per(7) + 12);
      chk(rd[STAT_SLOW_OK], 1'b1, "slow stable");
      apb(1'b1, CTL_OFS, 32'h1F);
      apb(1'b0, CTL_OFS, 32'h0);
      chk(rd, 32'h03, "control readback");
      apb(1'b1, OSC_OFS, 32'hFF);
      apb(1'b0, OSC_OFS, 32'h0);
      chk(rd, 32'h03, "osc readback");
      wait_switch(6 * per(7) + per(0) + 12);
      // Every selector code, pulse rate measured against the bus clock
      prev = 0;
      for (int k = 0; k < 8; k++) begin
         apb(1'b1, CTL_OFS, 32'(k << 5));
         wait_switch(6 * per(prev) + per(k) + 12);
         span(k == 7 ? 6250 : 640);
         ex = (k == 7) ? 10 : (512 >> k);
         chk_rng(dl[0], ex - 1, ex + 1, "system rate");
         chk_rng(dl[1], dl[0], dl[0], "cpu rate");
         if (k == 0)
            chk_rng(dl[2], 511, 513, "fast rate");
         if (k == 7) begin
            chk_rng(dl[4], 9, 11, "slow rate");
            chk_rng(dl[2], 4999, 5001, "fast on sub");
         end
         prev = k;
      end
      apb(1'b1, OSC_OFS, 32'h0);
      span(100);
      chk(fast_osc_run, 1'b0, "fast stopped");
      chk_rng(dl[2], 0, 0, "fast pulses off");
      apb(1'b0, OSC_OFS, 32'h0);
      chk(rd, 32'h0, "osc off");
      apb(1'b1, OSC_OFS, 32'h1);
      apb(1'b0, OSC_OFS, 32'h0);
      chk(rd, 32'h1, "stable cleared");
      span(20);
      apb(1'b0, OSC_OFS, 32'h0);
      chk(rd, 32'h3, "stable set");
      apb(1'b1, CTL_OFS, 32'h0);
      wait_switch(6 * per(7) + per(0) + 12);
      // Halt under each pair of idle bits; wake by irq, overflow, port pin
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, CTL_OFS, 32'(m));
         @(posedge pclk);
         halt_req <= 1'b1;
         @(posedge pclk);
         halt_req <= 1'b0;
         #1;
         chk(cpu_on, 1'b0, "cpu off");
         chk(watchdog_clear, 1'b1, "watchdog clear");
         chk({powerdown_flag, timeout_flag}, 2'b10, "halt flags");
         apb(1'b0, STAT_OFS, 32'h0);
         chk(rd[4:2], mode_tab[m], "mode");
         span(1300);
         chk_rng(dl[4], 1, 3, "slow in halt");
         chk_rng(dl[1], 0, 0, "cpu clock in halt");
         chk_rng(dl[3], m % 2, 3 * (m % 2), "sub in halt");
         chk_rng(dl[2], 1000 * (m / 2), 1100 * (m / 2), "fast in halt");
         @(posedge pclk);
         if (m == 2)
            porta_pins <= 8'hFE;
         else if (m == 1)
            watchdog_overflow <= 1'b1;
         else
            sys_irq <= 1'b1;
         @(posedge pclk);
         sys_irq <= 1'b0;
         watchdog_overflow <= 1'b0;
         n = 0;
         while (cpu_on !== 1'b1 && n < 8) begin
            @(posedge pclk);
            n++;
         end
         chk(cpu_on, 1'b1, "wake");
         if (m == 1)
            chk(timeout_flag, 1'b1, "timeout set");
         porta_pins <= 8'hFF;
      end
      @(posedge pclk);
      watchdog_clr_instr <= 1'b1;
      @(posedge pclk);
      watchdog_clr_instr <= 1'b0;
      #1 chk(powerdown_flag, 1'b0, "powerdown cleared");
      tally_and_finish();
   end
endmodule // tb_system_clock_and_power_modes
